// ==== duart_pkg.sv ====
package duart_pkg;
   // clock and reference
   localparam int CLOCK_HZ = 125000000;
   localparam int REF_HZ = 120000000;
   // reference ticks are made by a rational accumulator: 24 ticks per 25 clocks
   localparam logic [4:0] REF_STEP = 5'h18;
   localparam logic [4:0] REF_MOD = 5'h19;
   // oversampling per bit
   localparam logic [4:0] OVS_X16 = 5'h10;
   localparam logic [4:0] OVS_X10 = 5'h0a;
   // x16 keeps 2 of every 5 divider ticks: a 3 MHz base, so 14 bits reach 183 baud
   localparam logic [2:0] X16_STEP = 3'h2;
   localparam logic [2:0] X16_MOD = 3'h5;
   // divider layout
   localparam int PRESCALE_W = 14;
   localparam int FRAC_W = 4;
   localparam int DIV_W = PRESCALE_W + FRAC_W;
   // buffers
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 4096;
   localparam int PTR_W = 12;
   // latency timer
   localparam int MS_NS = 1000000;
   localparam int MICROFRAME_NS = 125000;
   localparam int CLK_NS = 8;
   localparam int MS_CYCLES = MS_NS / CLK_NS;
   localparam int UFRAME_CYCLES = MICROFRAME_NS / CLK_NS;
   localparam logic [8:0] LATENCY_RESET = 9'h010;
   localparam logic [8:0] LATENCY_MAX = 9'h100;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_BAUD = 8'h04;
   localparam logic [7:0] OFS_LATENCY = 8'h08;
   localparam logic [7:0] OFS_TXDATA = 8'h0c;
   localparam logic [7:0] OFS_RXDATA = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // control fields
   localparam int CTRL_X10 = 0;
   localparam int CTRL_PAR_EN = 1;
   localparam int CTRL_PAR_ODD = 2;
   localparam int CTRL_STOP2 = 3;
   localparam int CTRL_SEVEN = 4;
   localparam int CTRL_W = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   // baud reset: 312 + 8/16 gives 9600 baud at x16
   localparam logic [DIV_W-1:0] BAUD_RESET = 18'h20138;
   // status fields; bits 0..3 are sticky, write one to clear
   localparam int ST_PARITY_ERR = 0;
   localparam int ST_FRAME_ERR = 1;
   localparam int ST_OVERRUN = 2;
   localparam int ST_FLUSHED = 3;
   localparam int ST_TX_EMPTY = 4;
   localparam int ST_TX_FULL = 5;
   localparam int ST_RX_EMPTY = 6;
   localparam int ST_RX_FULL = 7;
   localparam int ST_BUSY = 8;
   localparam int ST_RATE_BAD = 9;
   localparam int ST_DEFAULT_CFG = 10;
   localparam int STICKY_W = 4;
   // ahb-lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} duart_tx_type;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} duart_rx_type;
endpackage : duart_pkg

// ==== duart_fifo_if.sv ====
`timescale 1ns/1ps
interface duart_fifo_if;
   logic push;
   logic [7:0] push_data;
   logic pop;
   logic [7:0] pop_data;
   logic full;
   logic empty;
   modport store (input push, input push_data, input pop, output pop_data, output full,
      output empty);
   modport user (output push, output push_data, output pop, input pop_data, input full,
      input empty);
endinterface : duart_fifo_if

// ==== duart_fifo.sv ====
`timescale 1ns/1ps
module duart_fifo
   import duart_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   duart_fifo_if.store port
);
   logic [DATA_W-1:0] mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0] count;
   wire do_push = port.push && !port.full;
   wire do_pop = port.pop && !port.empty;

   // first word falls through; push into a full buffer is dropped
   assign port.pop_data = mem[rd_ptr];
   assign port.full = (count == (PTR_W+1)'(FIFO_DEPTH));
   assign port.empty = (count == '0);

   // storage has no reset, only the pointers and the count do
   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[wr_ptr] <= port.push_data;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= wr_ptr + PTR_W'(do_push);
         rd_ptr <= rd_ptr + PTR_W'(do_pop);
         count <= count + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
      end
   end
endmodule : duart_fifo

// ==== duart_baud.sv ====
`timescale 1ns/1ps
module duart_baud
   import duart_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [PRESCALE_W-1:0] prescale,
   input wire logic [FRAC_W-1:0] frac,
   output logic sample_tick
);
   logic [4:0] ref_acc;
   logic [DIV_W:0] div_acc;
   // a zero prescale would tick on every reference tick, so it counts as one
   wire [PRESCALE_W-1:0] pre_eff = (prescale == '0) ? PRESCALE_W'(1) : prescale;
   wire [DIV_W:0] divisor = {1'b0, pre_eff, frac};
   wire [5:0] ref_sum = {1'b0, ref_acc} + {1'b0, REF_STEP};
   wire ref_tick = (ref_sum >= {1'b0, REF_MOD});
   wire [DIV_W:0] div_sum = div_acc + (DIV_W+1)'(16);
   wire div_hit = ref_tick && (div_sum >= divisor);

   // rational reference: 120 MHz ticks on a 125 MHz clock, no second clock domain
   always_ff @(posedge clock) begin
      if (rst) begin
         ref_acc <= '0;
      end else begin
         ref_acc <= ref_tick ? 5'(ref_sum - {1'b0, REF_MOD}) : ref_sum[4:0];
      end
   end

   // divide by prescale plus frac/16 in sixteenths of a reference tick
   always_ff @(posedge clock) begin
      if (rst) begin
         div_acc <= '0;
         sample_tick <= 1'b0;
      end else begin
         sample_tick <= div_hit;
         if (ref_tick) begin
            div_acc <= div_hit ? div_sum - divisor : div_sum;
         end
      end
   end
endmodule : duart_baud

// ==== duart_channel.sv ====
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - x16 or x10 sample clock from 120 MHz
// - 14-bit prescale plus 4 fraction bits
// - rates from 183 baud to 12 Mbaud
// - 7, 9, 10, 11 Mbaud unsupported
// - line driver enabled only while shifting out
// - power enable goes high during suspend
// - own 4 KB transmit and receive buffers
// - latency timeout flushes short receive data
// - channel has own generator and mode
// - no config memory means async serial defaults
// - external active-low reset resets the logic
module duart_channel
   import duart_pkg::*;
#(
   parameter int MS_COUNT = MS_CYCLES,
   parameter int UFRAME_COUNT = UFRAME_CYCLES
)
(
   input wire logic clock,
   input wire logic srst,
   input wire logic ext_reset_n,
   input wire logic usb_suspend,
   input wire logic cfg_mem_present,
   input wire logic cfg_mem_blank,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic rxd,
   output logic txd,
   output logic line_driver_enable,
   output logic suspend_power_on_n,
   output logic rx_flush,
   output logic default_config
);
   // internal reset: either source; ext pin is sampled synchronously
   wire rst = srst || !ext_reset_n;

   // software state
   logic [CTRL_W-1:0] ctrl;
   logic [PRESCALE_W-1:0] prescale;
   logic [FRAC_W-1:0] frac;
   logic [8:0] latency;
   logic [STICKY_W-1:0] sticky;
   logic cfg_captured;

   // bus data phase tracking
   logic dp_write;
   logic [7:0] dp_addr;

   duart_fifo_if tx_q ();
   duart_fifo_if rx_q ();

   duart_fifo u_tx_fifo (.clock(clock), .rst(rst), .port(tx_q));
   duart_fifo u_rx_fifo (.clock(clock), .rst(rst), .port(rx_q));

   logic sample_tick;
   // private divider per channel; nothing is shared with a sibling channel
   duart_baud u_baud (
      .clock(clock),
      .rst(rst),
      .prescale(prescale),
      .frac(frac),
      .sample_tick(sample_tick)
   );

   // x16 thins the divider ticks to 2 of 5; without it the slow end stops near 457 baud
   logic [2:0] gate_acc;
   wire [2:0] gate_sum = gate_acc + X16_STEP;
   wire gate_hit = (gate_sum >= X16_MOD);
   wire bit_tick = sample_tick && (ctrl[CTRL_X10] || gate_hit);

   // rational thinning keeps bit length exact over every 16 ticks
   always_ff @(posedge clock) begin
      if (rst) gate_acc <= 3'h0;
      else if (sample_tick) gate_acc <= gate_hit ? gate_sum - X16_MOD : gate_sum;
   end

   // bus decode
   wire addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
   wire [7:0] a_ofs = haddr[7:0];
   wire rd_rxdata = addr_phase && !hwrite && (a_ofs == OFS_RXDATA);
   wire wr_ctrl = dp_write && (dp_addr == OFS_CTRL);
   wire wr_baud = dp_write && (dp_addr == OFS_BAUD);
   wire wr_lat = dp_write && (dp_addr == OFS_LATENCY);
   wire wr_tx = dp_write && (dp_addr == OFS_TXDATA);
   wire wr_stat = dp_write && (dp_addr == OFS_STATUS);

   // rates above 6 Mbaud exist only as 12M/integer at x10, so any fraction there is off-grid
   wire rate_bad = ctrl[CTRL_X10] && (prescale <= PRESCALE_W'(1)) && (frac != '0);
   wire [4:0] ovs = ctrl[CTRL_X10] ? OVS_X10 : OVS_X16;
   wire [3:0] nbits = ctrl[CTRL_SEVEN] ? 4'h7 : 4'h8;

   duart_tx_type tx_state;
   duart_rx_type rx_state;
   wire tx_busy = (tx_state != TX_IDLE);
   wire rx_busy = (rx_state != RX_IDLE);

   wire [31:0] status_word = {21'h0, default_config, rate_bad, tx_busy || rx_busy,
      rx_q.full, rx_q.empty, tx_q.full, tx_q.empty, sticky};
   logic [31:0] rd_mux;
   always_comb begin
      unique case (a_ofs)
         OFS_CTRL: rd_mux = {27'h0, ctrl};
         OFS_BAUD: rd_mux = {14'h0, frac, prescale};
         OFS_LATENCY: rd_mux = {23'h0, latency};
         OFS_RXDATA: rd_mux = {24'h0, rx_q.pop_data};
         OFS_STATUS: rd_mux = status_word;
         default: rd_mux = 32'h0;
      endcase
   end

   // zero wait states: read data is taken in the address phase, ready for the data phase
   always_ff @(posedge clock) begin
      if (rst) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_write <= addr_phase && hwrite;
         dp_addr <= a_ofs;
         hrdata <= (addr_phase && !hwrite) ? rd_mux : 32'h0;
      end
   end

   // configuration registers
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
         prescale <= BAUD_RESET[PRESCALE_W-1:0];
         frac <= BAUD_RESET[DIV_W-1:PRESCALE_W];
         latency <= LATENCY_RESET;
      end else begin
         if (wr_ctrl) ctrl <= hwdata[CTRL_W-1:0];
         if (wr_baud) begin
            prescale <= hwdata[PRESCALE_W-1:0];
            frac <= hwdata[DIV_W-1:PRESCALE_W];
         end
         if (wr_lat) latency <= (hwdata > 32'(LATENCY_MAX)) ? LATENCY_MAX : hwdata[8:0];
      end
   end

   // strap capture one cycle after reset release, never inside the reset branch
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_captured <= 1'b0;
         default_config <= 1'b1;
      end else if (!cfg_captured) begin
         cfg_captured <= 1'b1;
         default_config <= !cfg_mem_present || cfg_mem_blank;
      end
   end

   // suspend drops transceiver power
   always_ff @(posedge clock) begin
      if (rst) suspend_power_on_n <= 1'b1;
      else suspend_power_on_n <= usb_suspend;
   end

   // host side pushes words for the line
   assign tx_q.push = wr_tx;
   assign tx_q.push_data = hwdata[7:0];

   // ---------------- transmitter
   logic [4:0] tx_tick;
   logic [3:0] tx_bit;
   logic [7:0] tx_shift;
   logic tx_par;
   logic tx_stop_n;
   wire tx_bit_end = bit_tick && (tx_tick == ovs - 5'h1);
   wire tx_next_char = !tx_q.empty;
   wire tx_launch = (tx_state == TX_IDLE && tx_next_char) ||
      (tx_state == TX_STOP && tx_bit_end && !(ctrl[CTRL_STOP2] && !tx_stop_n) && tx_next_char);
   assign tx_q.pop = tx_launch;

   always_ff @(posedge clock) begin
      if (rst || tx_state == TX_IDLE || tx_bit_end) tx_tick <= 5'h0;
      else if (bit_tick) tx_tick <= tx_tick + 5'h1;
   end

   // back-to-back characters go straight from stop to start so the enable never dips
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_state <= TX_IDLE;
         tx_bit <= 4'h0;
         tx_shift <= 8'h00;
         tx_par <= 1'b0;
         tx_stop_n <= 1'b0;
      end else if (tx_launch) begin
         tx_state <= TX_START;
         tx_shift <= tx_q.pop_data;
         tx_par <= ctrl[CTRL_PAR_ODD];
         tx_bit <= 4'h0;
         tx_stop_n <= 1'b0;
      end else if (tx_bit_end) begin
         unique case (tx_state)
            TX_START: tx_state <= TX_DATA;
            TX_DATA: begin
               tx_par <= tx_par ^ tx_shift[0];
               tx_shift <= {1'b0, tx_shift[7:1]};
               tx_bit <= tx_bit + 4'h1;
               if (tx_bit == nbits - 4'h1) tx_state <= ctrl[CTRL_PAR_EN] ? TX_PARITY : TX_STOP;
            end
            TX_PARITY: tx_state <= TX_STOP;
            TX_STOP: begin
               if (ctrl[CTRL_STOP2] && !tx_stop_n) tx_stop_n <= 1'b1;
               else tx_state <= TX_IDLE;
            end
            TX_IDLE: tx_state <= TX_IDLE;
         endcase
      end
   end

   // line level per state; idle and stop are high
   wire next_txd = (tx_state == TX_START) ? 1'b0 :
                   (tx_state == TX_DATA) ? tx_shift[0] :
                   (tx_state == TX_PARITY) ? tx_par : 1'b1;
   always_ff @(posedge clock) begin
      if (rst) begin
         txd <= 1'b1;
         line_driver_enable <= 1'b0;
      end else begin
         txd <= next_txd;
         line_driver_enable <= tx_busy;
      end
   end

   // ---------------- receiver
   // echo of our own transmission is masked by board logic on rxd
   logic [4:0] rx_tick;
   logic [3:0] rx_bit;
   logic [7:0] rx_shift;
   logic rx_par;
   wire [4:0] rx_target = (rx_state == RX_START) ? {1'b0, ovs[4:1]} - 5'h1 : ovs - 5'h1;
   wire rx_bit_end = bit_tick && (rx_tick == rx_target);
   wire [7:0] rx_word = ctrl[CTRL_SEVEN] ? {1'b0, rx_shift[7:1]} : rx_shift;
   wire rx_done = rx_bit_end && (rx_state == RX_STOP);
   wire rx_good = rx_done && rxd;
   assign rx_q.push = rx_good;
   assign rx_q.push_data = rx_word;

   always_ff @(posedge clock) begin
      if (rst || rx_state == RX_IDLE || rx_bit_end) rx_tick <= 5'h0;
      else if (bit_tick) rx_tick <= rx_tick + 5'h1;
   end

   // start is checked at mid-bit, then every bit is sampled at its centre
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_state <= RX_IDLE;
         rx_bit <= 4'h0;
         rx_shift <= 8'h00;
         rx_par <= 1'b0;
      end else if (rx_state == RX_IDLE) begin
         if (bit_tick && !rxd) rx_state <= RX_START;
         rx_bit <= 4'h0;
         rx_par <= ctrl[CTRL_PAR_ODD];
      end else if (rx_bit_end) begin
         unique case (rx_state)
            RX_START: rx_state <= rxd ? RX_IDLE : RX_DATA;
            RX_DATA: begin
               rx_shift <= {rxd, rx_shift[7:1]};
               rx_par <= rx_par ^ rxd;
               rx_bit <= rx_bit + 4'h1;
               if (rx_bit == nbits - 4'h1) rx_state <= ctrl[CTRL_PAR_EN] ? RX_PARITY : RX_STOP;
            end
            RX_PARITY: begin
               rx_par <= rx_par ^ rxd;
               rx_state <= RX_STOP;
            end
            RX_STOP: rx_state <= RX_IDLE;
            RX_IDLE: rx_state <= RX_IDLE;
         endcase
      end
   end

   // ---------------- latency timer
   logic [31:0] ms_cnt;
   logic [31:0] uf_cnt;
   logic [8:0] lat_ms;
   wire ms_tick = (ms_cnt == 32'(MS_COUNT - 1));
   wire uf_tick = (uf_cnt == 32'(UFRAME_COUNT - 1));
   // zero latency flushes every microframe; otherwise after the set number of ms
   wire flush_now = !rx_q.empty &&
      ((latency == 9'h0) ? uf_tick : (ms_tick && lat_ms == latency - 9'h1));
   assign rx_q.pop = rd_rxdata;

   always_ff @(posedge clock) begin
      if (rst) begin
         ms_cnt <= 32'h0;
         uf_cnt <= 32'h0;
      end else begin
         ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
         uf_cnt <= uf_tick ? 32'h0 : uf_cnt + 32'h1;
      end
   end

   // the wait restarts whenever the buffer drains or a flush is sent
   always_ff @(posedge clock) begin
      if (rst || rx_q.empty || flush_now) lat_ms <= 9'h0;
      else if (ms_tick) lat_ms <= lat_ms + 9'h1;
   end

   always_ff @(posedge clock) begin
      if (rst) rx_flush <= 1'b0;
      else rx_flush <= flush_now;
   end

   // sticky status: a new event in the clearing cycle survives
   wire [STICKY_W-1:0] events = {flush_now, rx_good && rx_q.full,
      rx_done && !rxd, rx_done && ctrl[CTRL_PAR_EN] && rx_par};
   wire [STICKY_W-1:0] clear_mask = wr_stat ? hwdata[STICKY_W-1:0] : '0;
   always_ff @(posedge clock) begin
      if (rst) sticky <= '0;
      else sticky <= (sticky & ~clear_mask) | events;
   end
endmodule : duart_channel

// ==== duart_channel_props.sv ====
`timescale 1ns/1ps
module duart_channel_props (
   input wire logic clock,
   input wire logic srst,
   input wire logic ext_reset_n,
   input wire logic usb_suspend,
   input wire logic cfg_mem_present,
   input wire logic cfg_mem_blank,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic txd,
   input wire logic line_driver_enable,
   input wire logic suspend_power_on_n,
   input wire logic rx_flush,
   input wire logic default_config
);
   // either reset source holds the logic
   wire rst_any = srst || !ext_reset_n;
   // zero-wait slave, never an error response
   property p_bus_ready;
      @(posedge clock) disable iff (rst_any) hreadyout && !hresp;
   endproperty
   a_bus_ready: assert property (p_bus_ready) else $error("slave stalled");
   property p_power;
      @(posedge clock) disable iff (rst_any) 1'b1 |=> suspend_power_on_n == $past(usb_suspend);
   endproperty
   a_power: assert property (p_power) else $error("power enable off suspend");
   property p_idle_high;
      @(posedge clock) disable iff (rst_any) !line_driver_enable |-> txd;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line low undriven");
   property p_start;
      @(posedge clock) disable iff (rst_any) $fell(txd) |-> line_driver_enable;
   endproperty
   a_start: assert property (p_start) else $error("start bit without driver");
   property p_release;
      @(posedge clock) disable iff (rst_any) $fell(line_driver_enable) |-> txd && $past(txd);
   endproperty
   a_release: assert property (p_release) else $error("driver dropped early");
   property p_flush_pulse;
      @(posedge clock) disable iff (rst_any) rx_flush |=> !rx_flush;
   endproperty
   a_flush_pulse: assert property (p_flush_pulse) else $error("flush too long");
   property p_ext_reset;
      @(posedge clock) disable iff (srst) !ext_reset_n |=>
         txd && !line_driver_enable && !rx_flush && default_config && suspend_power_on_n;
   endproperty
   a_ext_reset: assert property (p_ext_reset) else $error("external reset ignored");
   property p_default_cfg;
      @(posedge clock) disable iff (rst_any) $fell(rst_any) |=>
         default_config == $past(!cfg_mem_present || cfg_mem_blank);
   endproperty
   a_default_cfg: assert property (p_default_cfg) else $error("default mode wrong");
endmodule : duart_channel_props

// ==== duart_line_model.sv ====
`timescale 1ns/1ps
module duart_line_model (
   input wire logic txd,
   input wire logic line_driver_enable,
   input wire logic suspend_power_on_n,
   output logic rxd
);
   // far node level; failsafe bias keeps an undriven pair idle high
   logic remote = 1'b1;
   // half-duplex pair: our driver owns it only while enabled
   wire pair_level = line_driver_enable ? txd : remote;
   // echo masked by or-ing the enable; a disabled receiver floats to its pull-up
   assign rxd = pair_level | line_driver_enable | suspend_power_on_n;
   // far node sends a frame lsb first, bit time in ns
   task send(input logic [23:0] bits, input int n, input real bns);
      for (int i = 0; i < n; i++) begin
         remote = bits[i];
         #(bns);
      end
      remote = 1'b1;
   endtask : send
endmodule : duart_line_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
   import duart_pkg::*;
   localparam real BIT16 = 16.0 * 2.5 * 3.125 * 1000.0 / 120.0;
   localparam real BIT10 = 10.0 * 12.0 * 1000.0 / 120.0;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic ext_reset_n = 1'b1;
   logic usb_suspend = 1'b0;
   logic cfg_mem_present = 1'b0;
   logic cfg_mem_blank = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, txd, line_driver_enable, suspend_power_on_n, rx_flush, rxd;
   logic default_config, rdy_q;
   logic [31:0] hrdata, rd_q;
   int n_mismatch = 0;
   int samples_checked = 0;
   always #4 clock = ~clock;
   // bus answer captured at the edge itself, read back just after it
   always @(posedge clock) begin
      rd_q <= hrdata;
      rdy_q <= hreadyout;
   end
   duart_channel #(.MS_COUNT(50), .UFRAME_COUNT(20)) u_duart_channel (.clock(clock),
      .srst(srst), .ext_reset_n(ext_reset_n), .usb_suspend(usb_suspend),
      .cfg_mem_present(cfg_mem_present), .cfg_mem_blank(cfg_mem_blank), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd),
      .txd(txd), .line_driver_enable(line_driver_enable),
      .suspend_power_on_n(suspend_power_on_n), .rx_flush(rx_flush),
      .default_config(default_config));
   duart_line_model u_duart_line_model (.txd(txd), .line_driver_enable(line_driver_enable),
      .suspend_power_on_n(suspend_power_on_n), .rxd(rxd));
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   // single word transfer; waits on hready rather than assuming zero wait
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do begin @(posedge clock); #1; end while (rdy_q !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge clock); #1; end while (rdy_q !== 1'b1);
      rd = rd_q;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask : wr
   task rchk(input string name, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      chk(name, v & m, e);
   endtask : rchk
   // samples mid-bit, offset 2 ns so no sample lands on a clock edge
   task tx_check(input logic [23:0] exp, input int n, input real bns);
      int k;
      k = 0;
      while (txd !== 1'b0 && k < 3000) begin @(negedge clock); k++; end
      #(bns / 2.0 + 2.0);
      for (int i = 0; i < n; i++) begin
         chk("txd", 32'(txd), 32'(exp[i]));
         chk("drive_en", 32'(line_driver_enable), 32'h1);
         #(bns);
      end
      chk("drive_off", 32'(line_driver_enable), 32'h0);
   endtask : tx_check
   task wait_flush(output int k);
      k = 0;
      while (rx_flush !== 1'b1 && k < 300) begin @(negedge clock); k++; end
   endtask : wait_flush
   task t_reset;
      rchk("status", OFS_STATUS, 32'h450, 32'h7ff);
      rchk("ctrl", OFS_CTRL, 32'h0, 32'h1f);
      rchk("baud", OFS_BAUD, 32'h20138, 32'h3ffff);
      rchk("latency", OFS_LATENCY, 32'h10, 32'h1ff);
      rchk("unmapped", 8'h20, 32'h0, 32'hffffffff);
   endtask : t_reset
   task t_tx;
      wr(OFS_BAUD, 32'h8003);
      wr(OFS_TXDATA, 32'ha5);
      tx_check({14'h0, 1'b1, 8'ha5, 1'b0}, 10, BIT16);
      wr(OFS_TXDATA, 32'h3c);
      wr(OFS_TXDATA, 32'hc3);
      tx_check({4'h0, 1'b1, 8'hc3, 1'b0, 1'b1, 8'h3c, 1'b0}, 20, BIT16);
      rchk("echo", OFS_STATUS, 32'h40, 32'h40);
      wr(OFS_CTRL, 32'h0f);
      wr(OFS_BAUD, 32'h000c);
      wr(OFS_TXDATA, 32'h07);
      tx_check({12'h0, 2'b11, ~^8'h07, 8'h07, 1'b0}, 12, BIT10);
      wr(OFS_CTRL, 32'h11);
      wr(OFS_TXDATA, 32'h55);
      tx_check({15'h0, 1'b1, 7'h55, 1'b0}, 9, BIT10);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_BAUD, 32'h8003);
   endtask : t_tx
   task t_rx;
      int k;
      wr(OFS_LATENCY, 32'h3);
      @(negedge clock);
      u_duart_line_model.send({1'b1, 8'h3c, 1'b0}, 10, BIT16);
      wait_flush(k);
      chk("flush_wait", 32'(k >= 20 && k <= 110), 32'h1);
      rchk("flushed", OFS_STATUS, 32'h8, 32'h8);
      wr(OFS_STATUS, 32'h8);
      rchk("flush_clr", OFS_STATUS, 32'h0, 32'h8);
      rchk("rx_byte", OFS_RXDATA, 32'h3c, 32'hff);
      rchk("rx_empty", OFS_STATUS, 32'h40, 32'h40);
      wr(OFS_LATENCY, 32'h0);
      @(negedge clock);
      u_duart_line_model.send({1'b1, 8'h5a, 1'b0}, 10, BIT16);
      wait_flush(k);
      chk("uframe_wait", 32'(k <= 25), 32'h1);
      rchk("rx_byte", OFS_RXDATA, 32'h5a, 32'hff);
      @(negedge clock);
      u_duart_line_model.send({1'b0, 8'h11, 1'b0}, 10, BIT16);
      rchk("frame_err", OFS_STATUS, 32'h42, 32'h42);
      wr(OFS_STATUS, 32'hf);
      wr(OFS_LATENCY, 32'h12c);
      rchk("lat_clamp", OFS_LATENCY, 32'h100, 32'h1ff);
   endtask : t_rx
   task t_suspend;
      for (int i = 1; i >= 0; i--) begin
         @(posedge clock);
         usb_suspend <= i[0];
         repeat (2) @(posedge clock);
         #1;
         chk("power_n", 32'(suspend_power_on_n), 32'(i[0]));
      end
   endtask : t_suspend
   task t_rate;
      wr(OFS_CTRL, 32'h1);
      wr(OFS_BAUD, 32'h4001);
      rchk("rate_bad", OFS_STATUS, 32'h200, 32'h200);
      wr(OFS_CTRL, 32'h0);
      rchk("rate_ok", OFS_STATUS, 32'h0, 32'h200);
   endtask : t_rate
   task t_ext;
      wr(OFS_CTRL, 32'h0a);
      @(posedge clock);
      ext_reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      ext_reset_n <= 1'b1;
      rchk("ctrl_rst", OFS_CTRL, 32'h0, 32'h1f);
      rchk("lat_rst", OFS_LATENCY, 32'h10, 32'h1ff);
   endtask : t_ext
   // configuration memory present: programmed, then blank
   task t_cfg;
      for (int i = 0; i < 2; i++) begin
         @(posedge clock);
         cfg_mem_present <= 1'b1;
         cfg_mem_blank <= i[0];
         srst <= 1'b1;
         repeat (2) @(posedge clock);
         srst <= 1'b0;
         repeat (2) @(posedge clock);
         #1;
         chk("default_cfg", 32'(default_config), 32'(i[0]));
         rchk("st_default", OFS_STATUS, {21'h0, i[0], 10'h0}, 32'h400);
      end
   endtask : t_cfg
   initial begin
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      t_reset();
      t_tx();
      t_rx();
      t_suspend();
      t_rate();
      t_ext();
      t_cfg();
      stop_test();
   end
   // whole run needs under 100 us; four times that means a hang
   initial begin
      #400000;
      n_mismatch++;
      stop_test();
   end
endmodule : tb
bind duart_channel duart_channel_props u_duart_channel_props (.clock(clock), .srst(srst),
   .ext_reset_n(ext_reset_n), .usb_suspend(usb_suspend), .cfg_mem_present(cfg_mem_present),
   .cfg_mem_blank(cfg_mem_blank), .hreadyout(hreadyout), .hresp(hresp), .txd(txd),
   .line_driver_enable(line_driver_enable), .suspend_power_on_n(suspend_power_on_n),
   .rx_flush(rx_flush), .default_config(default_config));
